// ### core/rsf_status_flags.v
// Result status flag bank: live flags gathered during a command,
// latched at termination, and read by the host over Wishbone.
// Assumes the command sequencer drives single-cycle event pulses on
// clk_i and the drive lines arrive asynchronously from the cable.
// Expects the host to read each byte once per command.
// Expects a fresh start pulse before the next command's events.
// Expects done only after a start; a stray done is ignored.
// Bus is 32 bits wide; only the low byte is meaningful.
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rsf_defs.vh"

module rsf_status_flags (
  input wire clk_i,
  input wire rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Command sequencer
  input wire cmd_start_i,
  input wire [2:0] cmd_class_i,
  input wire cmd_done_i,
  input wire index_pulse_i,
  input wire id_mark_found_i,
  input wire data_mark_missed_i,
  input wire deleted_mark_seen_i,
  input wire data_crc_fail_i,
  input wire cyl_check_i,
  input wire [7:0] cyl_read_i,
  input wire [7:0] sector_id_params_i,
  input wire scan_equal_i,
  input wire scan_unmet_i,
  // Drive cable inputs (asynchronous)
  input wire drive_fault_i,
  input wire write_protect_i,
  input wire ready_i,
  input wire home_track_i,
  input wire double_sided_i,
  // Selection lines that this controller drives
  input wire side_select_i,
  input wire [1:0] drive_select_i,
  // Result availability
  output reg result_valid_o
);

  // Two-stage synchronisers for the five cable lines
  reg [4:0] sync1_q;
  reg [4:0] sync2_q;
  // Live flags during execution
  reg wp_hit_q;
  reg id_abs_q;
  reg del_q;
  reg crc_q;
  reg cyl_q;
  reg eq_q;
  reg unmet_q;
  reg bad_q;
  reg dat_abs_q;
  reg [1:0] idx_cnt_q;
  reg [2:0] class_q;
  reg busy_q;
  // Latched result bytes
  reg [7:0] sector_err_q;
  reg [7:0] data_err_q;
  reg [7:0] drive_st_q;
  reg [2:0] unread_q;

  wire [7:0] drive_live;
  wire is_write;
  wire is_readlike;
  wire is_scan;
  wire cyl_diff;
  wire id_timeout;
  wire bus_req;
  wire rd_sector;
  wire rd_data;
  wire rd_drive;
  wire clear;
  // Set conditions for each live flag, one per rule
  wire wp_set;
  wire id_set;
  wire dat_set;
  wire del_set;
  wire crc_set;
  wire cyl_set;
  wire bad_set;
  wire eq_set;
  wire unmet_set;
  // Result bytes as they would be latched now
  wire [7:0] sector_next;
  wire [7:0] data_next;
  wire latch_now;

  // How the bank is used
  // Start pulse clears every live flag and opens the busy window.
  // Class is captured with the start pulse and held to done.
  // Event pulses from the sequencer only count inside that window.
  // Done pulse closes the window and freezes the three bytes.
  // Sector and data bytes stay put until the next done; the drive byte stays put until its offset is read.
  // Pending bits at the status offset show which bytes are unread.
  // Result valid is registered: high one cycle after any pending bit is set.
  // Drive byte follows the cable again once it has been read.
  // Index pulse counting
  // Counter restarts at start and at every ID mark.
  // Second pulse with no mark in between sets the ID flag.
  // Counter saturates so a long search cannot wrap it.
  // Cylinder checks
  // Compare happens only in the cycle of the check pulse.
  // All-ones cylinder also counts as a plain mismatch.
  // Bus side
  // Ack follows a request by one cycle and lasts one cycle.
  // Held strobe retriggers every other cycle: ack blocks only the take in its own cycle.
  // Read data is registered and stands in the ack cycle.
  // Unmapped offsets read zero rather than a stale value.
  // Limitations
  // Events in the done cycle miss the frozen bytes by design.
  // Cable levels lag two clocks behind the pins.
  // Selection outputs are same-clock and need no synchroniser.
  // Writes are acknowledged and dropped; the bank is read-only.
  // Only bits 7:0 of the data bus carry status.
  // Trade-offs
  // Flags are sticky for a whole command, so a host sees any hit.
  // The next command's done overwrites unread results rather than stalling.
  // Done beats a read in the same cycle, so a new result is never lost.
  // Separate processes per flag keep each set condition local.

  // Register select by word offset
  function sel_hit;
    input [3:0] adr;
    input [3:0] ofs;
    begin
      sel_hit = (adr[3:2] == ofs[3:2]);
    end
  endfunction

  // Command class membership test
  function class_is;
    input [2:0] cls;
    input [2:0] code;
    begin
      class_is = (cls == code);
    end
  endfunction

  // Synchronise cable lines; first stage feeds only the second
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {drive_fault_i, write_protect_i, ready_i, home_track_i, double_sided_i};
      sync2_q <= sync1_q;
    end
  end

  // Drive state byte, live view
  assign drive_live = {sync2_q[4],
                       sync2_q[3],
                       sync2_q[2],
                       sync2_q[1],
                       sync2_q[0],
                       side_select_i,
                       drive_select_i};

  assign clear = cmd_start_i;
  assign is_write = busy_q && (class_is(class_q, `RSF_CMD_WRITE) ||
                               class_is(class_q, `RSF_CMD_WRDEL) ||
                               class_is(class_q, `RSF_CMD_FORMAT));
  assign is_scan = busy_q && class_is(class_q, `RSF_CMD_SCAN);
  assign is_readlike = busy_q && (class_is(class_q, `RSF_CMD_READ) || is_scan);
  assign cyl_diff = cyl_check_i && (cyl_read_i != sector_id_params_i);
  // Second index pulse with no ID mark yet
  assign id_timeout = busy_q && index_pulse_i && !id_mark_found_i &&
                      (idx_cnt_q == `RSF_IDX_LIMIT - 2'h1);

  // Flag set conditions; each only inside the busy window
  assign wp_set = is_write && sync2_q[3];
  assign id_set = id_timeout || (busy_q && data_mark_missed_i);
  assign dat_set = busy_q && data_mark_missed_i;
  assign del_set = is_readlike && deleted_mark_seen_i;
  assign crc_set = busy_q && data_crc_fail_i;
  assign cyl_set = busy_q && cyl_diff;
  assign bad_set = busy_q && cyl_diff && (cyl_read_i == `RSF_CYL_BAD);
  assign eq_set = is_scan && scan_equal_i;
  assign unmet_set = is_scan && scan_unmet_i;

  // Result byte images; bit 7 of the data byte is tied low
  assign sector_next = {6'h00, wp_hit_q, id_abs_q};
  assign data_next = {1'b0, del_q, crc_q, cyl_q, eq_q, unmet_q, bad_q, dat_abs_q};
  assign latch_now = busy_q && cmd_done_i;

  // Index pulse counter, restarted by every ID mark
  always @(posedge clk_i) begin
    if (rst_i || clear || id_mark_found_i) begin
      idx_cnt_q <= `RSF_RST_IDX;
    end else if (busy_q && index_pulse_i && idx_cnt_q != `RSF_IDX_LIMIT) begin
      idx_cnt_q <= idx_cnt_q + 2'h1;
    end
  end

  // Command window and class, held from start to done
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= 1'b0;
      class_q <= `RSF_CMD_NONE;
    end else if (clear) begin
      busy_q <= 1'b1;
      class_q <= cmd_class_i;
    end else if (cmd_done_i) begin
      busy_q <= 1'b0;
    end
  end

  // Write protect hit; a fresh start discards the old value
  always @(posedge clk_i) begin
    if (rst_i || clear) begin
      wp_hit_q <= 1'b0;
    end else if (wp_set) begin
      wp_hit_q <= 1'b1;
    end
  end

  // Missing ID sync, also raised with a missed data mark
  always @(posedge clk_i) begin
    if (rst_i || clear) begin
      id_abs_q <= 1'b0;
    end else if (id_set) begin
      id_abs_q <= 1'b1;
    end
  end

  // Missing data sync, set only by a missed data mark, not by the index timeout
  always @(posedge clk_i) begin
    if (rst_i || clear) begin
      dat_abs_q <= 1'b0;
    end else if (dat_set) begin
      dat_abs_q <= 1'b1;
    end
  end

  // Deleted sector seen, read and scan only
  always @(posedge clk_i) begin
    if (rst_i || clear) begin
      del_q <= 1'b0;
    end else if (del_set) begin
      del_q <= 1'b1;
    end
  end

  // Data field CRC failure
  always @(posedge clk_i) begin
    if (rst_i || clear) begin
      crc_q <= 1'b0;
    end else if (crc_set) begin
      crc_q <= 1'b1;
    end
  end

  // Cylinder mismatch against the identifier parameters
  always @(posedge clk_i) begin
    if (rst_i || clear) begin
      cyl_q <= 1'b0;
    end else if (cyl_set) begin
      cyl_q <= 1'b1;
    end
  end

  // Bad track: mismatch with an all-ones cylinder
  always @(posedge clk_i) begin
    if (rst_i || clear) begin
      bad_q <= 1'b0;
    end else if (bad_set) begin
      bad_q <= 1'b1;
    end
  end

  // Scan equal hit
  always @(posedge clk_i) begin
    if (rst_i || clear) begin
      eq_q <= 1'b0;
    end else if (eq_set) begin
      eq_q <= 1'b1;
    end
  end

  // Scan not satisfied on the cylinder
  always @(posedge clk_i) begin
    if (rst_i || clear) begin
      unmet_q <= 1'b0;
    end else if (unmet_set) begin
      unmet_q <= 1'b1;
    end
  end

  // Wishbone decode: single-cycle ack, dropped the cycle after
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_sector = bus_req && !wb_we_i && sel_hit(wb_adr_i, `RSF_OFS_SECTOR);
  assign rd_data = bus_req && !wb_we_i && sel_hit(wb_adr_i, `RSF_OFS_DATA);
  assign rd_drive = bus_req && !wb_we_i && sel_hit(wb_adr_i, `RSF_OFS_DRIVE);

  // Sector byte: frozen at termination, held until the next termination
  always @(posedge clk_i) begin
    if (rst_i) begin
      sector_err_q <= `RSF_RST_BYTE;
    end else if (latch_now) begin
      sector_err_q <= sector_next;
    end
  end

  // Data byte: frozen at termination, held until the next termination
  always @(posedge clk_i) begin
    if (rst_i) begin
      data_err_q <= `RSF_RST_BYTE;
    end else if (latch_now) begin
      data_err_q <= data_next;
    end
  end

  // Drive byte: frozen at termination, tracks the lines when not pending
  always @(posedge clk_i) begin
    if (rst_i) begin
      drive_st_q <= `RSF_RST_BYTE;
    end else if (latch_now || !unread_q[2]) begin
      drive_st_q <= drive_live;
    end
  end

  // Pending bits; termination wins over a read so no result is lost
  always @(posedge clk_i) begin
    if (rst_i) begin
      unread_q <= 3'h0;
    end else if (latch_now) begin
      unread_q <= 3'h7;
    end else begin
      if (rd_sector)
        unread_q[0] <= 1'b0;
      if (rd_data)
        unread_q[1] <= 1'b0;
      if (rd_drive)
        unread_q[2] <= 1'b0;
    end
  end

  // Bus answer; writes are accepted and ignored, unmapped reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      result_valid_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
      result_valid_o <= (unread_q != 3'h0);
      if (rd_sector)
        wb_dat_o <= {24'h000000, sector_err_q};
      else if (rd_data)
        wb_dat_o <= {24'h000000, data_err_q};
      else if (rd_drive)
        wb_dat_o <= {24'h000000, drive_st_q};
      else if (bus_req && !wb_we_i && sel_hit(wb_adr_i, `RSF_OFS_STAT))
        wb_dat_o <= {29'h00000000, unread_q};
      else
        wb_dat_o <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// ### core/rsf_defs.vh
// Constants for the result status flag bank: register offsets,
// bit positions, reset values and command codes.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
// Behaviour
// - Write protect during write sets write-protect-hit
// - No ID mark after two index pulses
// - Missed data mark sets both sync flags
// - Data error byte bit 7 reads zero
// - Deleted mark in read/scan sets flag
// - Data field CRC failure sets flag
// - Medium cylinder differs sets cylinder-mismatch
// - Scan equal condition sets compare-equal
// - Scan with no match sets compare-unmet
// - Mismatched cylinder all ones sets bad-track
// - No data mark while reading sets flag
// - Drive byte bit 7 shows fault
// - Drive byte bit 6 shows write protect
// - Drive byte bit 5 shows ready
// - Drive byte bit 4 shows home track
// - Drive byte bit 3 shows double sided
// - Drive byte bit 2 shows side select
// - Drive byte bits 1:0 show drive select
`ifndef RSF_DEFS_VH
`define RSF_DEFS_VH

// Register byte offsets
`define RSF_OFS_SECTOR 4'h0
`define RSF_OFS_DATA 4'h4
`define RSF_OFS_DRIVE 4'h8
`define RSF_OFS_STAT 4'hC

// Second status byte bit positions
`define RSF_B_WP_HIT 1
`define RSF_B_ID_ABS 0
// Third status byte bit positions
`define RSF_B_ZERO 7
`define RSF_B_DEL 6
`define RSF_B_CRC 5
`define RSF_B_CYL 4
`define RSF_B_EQ 3
`define RSF_B_UNMET 2
`define RSF_B_BAD 1
`define RSF_B_DAT_ABS 0

// Reset values
`define RSF_RST_BYTE 8'h00
`define RSF_RST_IDX 2'h0

// Index pulses before the ID mark is declared missing
`define RSF_IDX_LIMIT 2'h2
// Cylinder value marking a bad track
`define RSF_CYL_BAD 8'hFF

// Command classes from the sequencer
`define RSF_CMD_NONE 3'h0
`define RSF_CMD_READ 3'h1
`define RSF_CMD_WRITE 3'h2
`define RSF_CMD_WRDEL 3'h3
`define RSF_CMD_FORMAT 3'h4
`define RSF_CMD_SCAN 3'h5
`define RSF_CMD_OTHER 3'h6

`endif

// ### testbench/rsf_monitor.sv
// Checker for the status flag bank ports.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/1ps
`default_nettype none
module rsf_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic cmd_done_i,
  input wire logic side_select_i,
  input wire logic [1:0] drive_select_i,
  input wire logic result_valid_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request taken, then a read answer
  sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence drv_rd_s; wb_ack_o && $past(wb_adr_i) == 4'h8; endsequence
  // Bus answers after one cycle, as one pulse
  req_ack_a: assert property (req_s |=> wb_ack_o) else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack with no request");
  byte_wide_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper bits set");
  bit7_zero_a: assert property (wb_ack_o && $past(wb_adr_i) == 4'h4 |-> !wb_dat_o[7])
    else $error("data byte bit 7 set");
  // Results show two cycles after termination and leave only through reads
  valid_rise_a: assert property ($rose(result_valid_o) |-> $past(cmd_done_i, 2))
    else $error("result valid without done");
  valid_fall_a: assert property ($fell(result_valid_o) |-> $past(wb_ack_o) ||
    $past(wb_ack_o, 2)) else $error("result dropped unread");
  // Live drive byte carries the selection outputs
  drv_sel_a: assert property (drv_rd_s ##0 (!$past(result_valid_o) && !$past(cmd_done_i) &&
    !$past(cmd_done_i, 2)) |-> wb_dat_o[2:0] == {$past(side_select_i), $past(drive_select_i)})
    else $error("drive select mismatch");
endmodule
bind rsf_status_flags rsf_monitor u_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .cmd_done_i, .side_select_i, .drive_select_i, .result_valid_o);
`default_nettype wire

// ### testbench/rsf_drive_model.sv
// Drive side model: the cable status levels.
// Assumes the bench names the levels it wants.
`timescale 1ns/1ps
`default_nettype none
module rsf_drive_model (
  input wire logic clk_i,
  input wire logic [4:0] want_i,
  output logic [4:0] lines_o
);
  // Levels settle a cycle late, like a slow drive
  always @(posedge clk_i) begin
    lines_o <= want_i;
  end
endmodule
`default_nettype wire

// ### testbench/rsf_tb.sv
// Bench for the status flag bank: commands, then byte reads.
// Assumes the drive model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "rsf_defs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module testbench;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, rv, side = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] rd, d, wd = 32'h0;
  logic [9:0] ev = 10'h000;
  logic [2:0] cls = 3'h0;
  logic [7:0] cyl = 8'h00;
  logic [4:0] want = 5'h00, lines;
  logic [1:0] sel = 2'h0;
  int n_errors = 0, tests_run = 0;
  rsf_drive_model u_drv (.clk_i, .want_i(want), .lines_o(lines));
  rsf_status_flags DUT (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i({4{cyc}}), .wb_dat_o(rd), .wb_ack_o(ack),
    .cmd_start_i(ev[8]), .cmd_class_i(cls), .cmd_done_i(ev[9]), .index_pulse_i(ev[0]),
    .id_mark_found_i(ev[1]), .data_mark_missed_i(ev[2]), .deleted_mark_seen_i(ev[3]),
    .data_crc_fail_i(ev[4]), .cyl_check_i(ev[5]), .cyl_read_i(cyl),
    .sector_id_params_i(8'h03), .scan_equal_i(ev[6]), .scan_unmet_i(ev[7]),
    .drive_fault_i(lines[4]), .write_protect_i(lines[3]), .ready_i(lines[2]),
    .home_track_i(lines[1]), .double_sided_i(lines[0]), .side_select_i(side),
    .drive_select_i(sel), .result_valid_o(rv));
  initial forever #5 clk_i = ~clk_i;
  task tick; @(posedge clk_i); endtask
  // One classic cycle; no latency assumed
  task wb(input logic w, input logic [3:0] a);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= {32{w}};
    tick;
    while (ack !== 1'b1) tick;
    d = rd;
    cyc <= 0;
    stb <= 0;
    tick;
  endtask
  // Idle cycle after each pulse so no signal is driven twice at one edge
  task pulse(input logic [9:0] v); ev <= v; tick; ev <= 10'h000; tick; endtask
  task setup(input logic [4:0] w, input logic s, input logic [1:0] u, input logic [7:0] c);
    want <= w;
    side <= s;
    sel <= u;
    cyl <= c;
  endtask
  // One command, then all three bytes read back
  task run(input logic [2:0] c, input logic [9:0] e1, e2, input logic [7:0] xs, xd);
    cls <= c;
    pulse(10'h100);
    pulse(e1);
    pulse(e2);
    pulse(10'h200);
    repeat (2) tick;
    `CHK(rv, 1'b1)
    wb(0, 4'hC);
    `CHK(d[7:0], 8'h07)
    wb(0, 4'h0);
    `CHK(d[7:0], xs)
    wb(0, 4'h4);
    `CHK(d[7:0], xd)
    wb(0, 4'h8);
    `CHK(d[7:0], {want, side, sel})
    tick;
    `CHK(rv, 1'b0)
    $display("test done, class %0d", c);
  endtask
  task stop_test;
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Whole run is about 150 cycles
  initial begin
    repeat (2000) tick;
    n_errors++;
    stop_test;
  end
  initial begin
    repeat (8) tick;
    rst_i <= 0;
    tick;
    wb(1, 4'h4);
    for (int a = 0; a < 16; a += 2) begin
      wb(0, a[3:0]);
      `CHK(d, 32'h0)
    end
    $display("test done, reset and refused write");
    setup(5'h15, 1, 2'h2, 8'hFF);
    run(`RSF_CMD_READ, 10'h03C, 10'h000, 8'h01, 8'h73);
    setup(5'h0A, 0, 2'h1, 8'h05);
    run(`RSF_CMD_SCAN, 10'h0E8, 10'h000, 8'h00, 8'h5C);
    setup(5'h08, 1, 2'h3, 8'h03);
    run(`RSF_CMD_WRITE, 10'h009, 10'h041, 8'h03, 8'h00);
    run(`RSF_CMD_WRDEL, 10'h000, 10'h000, 8'h02, 8'h00);
    run(`RSF_CMD_FORMAT, 10'h000, 10'h000, 8'h02, 8'h00);
    stop_test;
  end
endmodule
`default_nettype wire
